/* File: spr_event_bank.sv */
// sticky event flags, masked status and the combined interrupt level
`timescale 1ns/1ps
module spr_event_bank #(
  parameter int N = spr_pkg::NUM_SRC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // raw conditions and mask
  input wire logic [N-1:0] raw_in,
  input wire logic [N-1:0] mask_in,
  // read of the event register clears the flags
  input wire logic clr_in,
  // results
  output logic [N-1:0] sticky_out,
  output logic [N-1:0] masked_out,
  output logic irq_out
);
  typedef struct packed {
    logic [N-1:0] raw_prev;
    logic [N-1:0] sticky;
    logic [N-1:0] masked;
    logic irq;
  } spr_evt_state_type;

  spr_evt_state_type s_q;
  spr_evt_state_type s_d;
  logic [N-1:0] sticky_nx;

  // per source: a rising raw level sets the flag, and the set beats a clear in the same cycle
  for (genvar i = 0; i < N; i++)
  begin : g_src
    assign sticky_nx[i] = (raw_in[i] & ~s_q.raw_prev[i]) | (s_q.sticky[i] & ~clr_in);
  end

  // next state
  always_comb
  begin
    s_d = s_q;
    s_d.raw_prev = raw_in;
    s_d.sticky = sticky_nx;
    s_d.masked = raw_in & mask_in;
    s_d.irq = |(sticky_nx & mask_in);
  end

  // state register
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign sticky_out = s_q.sticky;
  assign masked_out = s_q.masked;
  assign irq_out = s_q.irq;
endmodule

/* File: spr_pkg.sv */
// shared constants for the serial port prescale and interrupt mask register bank
package spr_pkg;
  // register byte offsets on the control bus
  localparam logic [7:0] OFS_PRESCALE = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_RAW = 8'h08;
  localparam logic [7:0] OFS_MASKED = 8'h0C;
  localparam logic [7:0] OFS_EVENT = 8'h10;
  // register word decode uses these address bits
  localparam int ADDR_LO = 2;
  localparam int ADDR_HI = 7;
  // prescale divisor field
  localparam int DIV_W = 8;
  localparam logic [7:0] DIV_RESET = 8'h02;
  localparam logic [7:0] DIV_LSB_CLR = 8'hFE;
  localparam logic [7:0] DIV_MIN = 8'h02;
  localparam logic [7:0] DIV_MAX = 8'hFE;
  // interrupt sources and their bit positions
  localparam int NUM_SRC = 4;
  localparam int IRQ_TX = 3;
  localparam int IRQ_RX = 2;
  localparam int IRQ_RT = 1;
  localparam int IRQ_ROR = 0;
  localparam logic [3:0] MASK_RESET = 4'h0;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
  // core clock rate
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
endpackage

/* File: spr_prescaler.sv */
// divides the serial input clock into a one-cycle enable pulse
`timescale 1ns/1ps
module spr_prescaler #(
  parameter int DIV_W = spr_pkg::DIV_W
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // divisor from the register bank
  input wire logic [DIV_W-1:0] divisor_in,
  // divided enable
  output logic tick_out
);
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic tick;
  } spr_div_state_type;

  spr_div_state_type s_q;
  spr_div_state_type s_d;

  // count 0..divisor-1; the >= compare recovers at once when the divisor shrinks
  always_comb
  begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (divisor_in < DIV_W'(spr_pkg::DIV_MIN))
    begin
      // a divisor below two (zero or one) stops the generator rather than dividing by nothing
      s_d.cnt = '0;
    end
    else if (s_q.cnt >= DIV_W'(divisor_in - 1'b1))
    begin
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end
    else
    begin
      s_d.cnt = DIV_W'(s_q.cnt + 1'b1);
    end
  end

  // state register
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign tick_out = s_q.tick;
endmodule

/* File: spr_regs.sv */
// prescale and interrupt mask register bank with an axi4-lite slave port
`timescale 1ns/1ps
module spr_regs #(
  parameter int AXI_AW = 8
) (
  // clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic RESETN_IN,
  // axi4-lite write address
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [AXI_AW-1:0] S_AXI_AWADDR_IN,
  input wire logic [2:0] S_AXI_AWPROT_IN,
  // axi4-lite write data
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  // axi4-lite write response
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  output logic [1:0] S_AXI_BRESP_OUT,
  // axi4-lite read address
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  input wire logic [AXI_AW-1:0] S_AXI_ARADDR_IN,
  input wire logic [2:0] S_AXI_ARPROT_IN,
  // axi4-lite read data
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  // raw interrupt conditions from the port core, same clock
  input wire logic [spr_pkg::NUM_SRC-1:0] RAW_IRQ_IN,
  // prescaler results
  output logic [spr_pkg::DIV_W-1:0] PRESCALE_DIVISOR_OUT,
  output logic PRESCALE_TICK_OUT,
  // interrupt results
  output logic [spr_pkg::NUM_SRC-1:0] MASKED_IRQ_STATUS_OUT,
  output logic IRQ_OUT
);
  typedef struct packed {
    logic aw_held;
    logic [AXI_AW-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [spr_pkg::DIV_W-1:0] prescale_divisor;
    logic [spr_pkg::NUM_SRC-1:0] interrupt_mask;
  } spr_regs_state_type;

  spr_regs_state_type s_q;
  spr_regs_state_type s_d;

  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic do_write;
  logic [7:0] wr_ofs;
  logic [7:0] rd_ofs;
  logic event_clr;
  logic [spr_pkg::NUM_SRC-1:0] sticky;
  logic [spr_pkg::NUM_SRC-1:0] masked;
  logic irq;
  logic tick;

  // one write at a time: address and data are each parked until both are in
  assign S_AXI_AWREADY_OUT = !s_q.aw_held && !s_q.bvalid;
  assign S_AXI_WREADY_OUT = !s_q.w_held && !s_q.bvalid;
  assign S_AXI_ARREADY_OUT = !s_q.rvalid;
  assign aw_hs = S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT;
  assign w_hs = S_AXI_WVALID_IN && S_AXI_WREADY_OUT;
  assign ar_hs = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
  assign do_write = s_q.aw_held && s_q.w_held;

  // word decode; upper address bits beyond the map make the access unmapped
  assign wr_ofs = {s_q.aw_addr[spr_pkg::ADDR_HI:spr_pkg::ADDR_LO], 2'b00};
  assign rd_ofs = {S_AXI_ARADDR_IN[spr_pkg::ADDR_HI:spr_pkg::ADDR_LO], 2'b00};

  // reading the event register clears its flags; fresh events still win
  assign event_clr = ar_hs && (rd_ofs == spr_pkg::OFS_EVENT);

  // next-state logic for the bus slave and the two writable registers
  always_comb
  begin
    s_d = s_q;
    // write address and data capture
    if (aw_hs)
    begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = S_AXI_AWADDR_IN;
    end
    if (w_hs)
    begin
      s_d.w_held = 1'b1;
      s_d.w_data = S_AXI_WDATA_IN;
      s_d.w_strb = S_AXI_WSTRB_IN;
    end
    // perform the write once both halves are parked
    if (do_write)
    begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = spr_pkg::RESP_OKAY;
      case (wr_ofs)
        spr_pkg::OFS_PRESCALE:
        begin
          // only byte 0 carries the divisor; reserved upper bits are dropped
          if (s_q.w_strb[0])
            s_d.prescale_divisor = s_q.w_data[spr_pkg::DIV_W-1:0] & spr_pkg::DIV_LSB_CLR;
        end
        spr_pkg::OFS_MASK:
        begin
          // reserved mask bits are not stored, so they stay zero
          if (s_q.w_strb[0])
            s_d.interrupt_mask = s_q.w_data[spr_pkg::NUM_SRC-1:0];
        end
        spr_pkg::OFS_RAW, spr_pkg::OFS_MASKED, spr_pkg::OFS_EVENT:
        begin
          // status registers ignore writes but answer okay
          s_d.bresp = spr_pkg::RESP_OKAY;
        end
        default:
        begin
          s_d.bresp = spr_pkg::RESP_DECERR;
        end
      endcase
    end
    // write response retires on bready
    if (s_q.bvalid && S_AXI_BREADY_IN)
    begin
      s_d.bvalid = 1'b0;
      s_d.bresp = spr_pkg::RESP_OKAY;
    end
    // read data retires on rready
    if (s_q.rvalid && S_AXI_RREADY_IN)
    begin
      s_d.rvalid = 1'b0;
      s_d.rdata = spr_pkg::DATA_ZERO;
      s_d.rresp = spr_pkg::RESP_OKAY;
    end
    // read: data are sampled at the address handshake and held stable
    if (ar_hs)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = spr_pkg::RESP_OKAY;
      s_d.rdata = spr_pkg::DATA_ZERO;
      case (rd_ofs)
        spr_pkg::OFS_PRESCALE:
        begin
          // reserved bits read as zero, which is one of the allowed values
          s_d.rdata[spr_pkg::DIV_W-1:0] = s_q.prescale_divisor;
        end
        spr_pkg::OFS_MASK:
        begin
          s_d.rdata[spr_pkg::NUM_SRC-1:0] = s_q.interrupt_mask;
        end
        spr_pkg::OFS_RAW:
        begin
          s_d.rdata[spr_pkg::NUM_SRC-1:0] = RAW_IRQ_IN;
        end
        spr_pkg::OFS_MASKED:
        begin
          // no side effect: plain combination of raw state and mask
          s_d.rdata[spr_pkg::NUM_SRC-1:0] = RAW_IRQ_IN & s_q.interrupt_mask;
        end
        spr_pkg::OFS_EVENT:
        begin
          s_d.rdata[spr_pkg::NUM_SRC-1:0] = sticky;
        end
        default:
        begin
          s_d.rresp = spr_pkg::RESP_DECERR;
        end
      endcase
    end
  end

  // state register; the mask comes out of reset all masked
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      s_q <= '0;
      s_q.prescale_divisor <= spr_pkg::DIV_RESET;
      s_q.interrupt_mask <= spr_pkg::MASK_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // divided serial clock enable, used by the later bit-rate stage
  spr_prescaler #(
    .DIV_W(spr_pkg::DIV_W)
  ) u_prescaler (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RESETN_IN),
    .divisor_in(s_q.prescale_divisor),
    .tick_out(tick)
  );

  // per-source gating of raw conditions by the mask bits
  spr_event_bank #(
    .N(spr_pkg::NUM_SRC)
  ) u_events (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RESETN_IN),
    .raw_in(RAW_IRQ_IN),
    .mask_in(s_q.interrupt_mask),
    .clr_in(event_clr),
    .sticky_out(sticky),
    .masked_out(masked),
    .irq_out(irq)
  );

  // outputs
  assign S_AXI_BVALID_OUT = s_q.bvalid;
  assign S_AXI_BRESP_OUT = s_q.bresp;
  assign S_AXI_RVALID_OUT = s_q.rvalid;
  assign S_AXI_RDATA_OUT = s_q.rdata;
  assign S_AXI_RRESP_OUT = s_q.rresp;
  assign PRESCALE_DIVISOR_OUT = s_q.prescale_divisor;
  assign PRESCALE_TICK_OUT = tick;
  assign MASKED_IRQ_STATUS_OUT = masked;
  assign IRQ_OUT = irq;

  // checks on the register bank, all in the core clock domain
  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (!RESETN_IN);

  // divisor never holds an odd value
  property p_div_even;
    PRESCALE_DIVISOR_OUT[0] == 1'b0;
  endproperty
  a_div_even: assert property (p_div_even)
    else $error("prescale divisor has its low bit set");

  // a divisor of two gives a tick every second cycle once running
  property p_tick_two;
    (PRESCALE_TICK_OUT && PRESCALE_DIVISOR_OUT == 8'h02) ##1 (PRESCALE_DIVISOR_OUT == 8'h02)
      |-> !PRESCALE_TICK_OUT ##1 PRESCALE_TICK_OUT;
  endproperty
  a_tick_two: assert property (p_tick_two)
    else $error("divide by two does not tick every second cycle");

  // a byte-0 write to the prescale register lands with bit 0 cleared
  property p_div_write;
    (do_write && wr_ofs == spr_pkg::OFS_PRESCALE && s_q.w_strb[0])
      |=> PRESCALE_DIVISOR_OUT == ($past(s_q.w_data[7:0]) & 8'hFE);
  endproperty
  a_div_write: assert property (p_div_write)
    else $error("prescale write not stored as even divisor");

  // prescale reads show zero above the divisor field
  property p_pre_resv;
    (ar_hs && rd_ofs == spr_pkg::OFS_PRESCALE)
      |=> S_AXI_RVALID_OUT && S_AXI_RDATA_OUT[31:8] == 24'h00_0000;
  endproperty
  a_pre_resv: assert property (p_pre_resv)
    else $error("prescale reserved bits read nonzero");

  // mask is zero in the first cycle after reset release
  property p_mask_reset;
    !$past(RESETN_IN) |-> s_q.interrupt_mask == 4'h0;
  endproperty
  a_mask_reset: assert property (p_mask_reset)
    else $error("interrupt mask not cleared by reset");

  // a mask write stores the low four written bits in the mask register
  property p_mask_write;
    (do_write && wr_ofs == spr_pkg::OFS_MASK && s_q.w_strb[0])
      |=> s_q.interrupt_mask == $past(s_q.w_data[3:0]);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("interrupt mask write not stored");

  // mask reads return the mask with reserved bits zero
  property p_mask_read;
    (ar_hs && rd_ofs == spr_pkg::OFS_MASK)
      |=> S_AXI_RDATA_OUT == {28'h000_0000, $past(s_q.interrupt_mask)};
  endproperty
  a_mask_read: assert property (p_mask_read)
    else $error("interrupt mask read back wrong");

  // each masked status bit follows raw and mask one cycle later
  property p_tx_gate;
    ##1 MASKED_IRQ_STATUS_OUT[3] == ($past(RAW_IRQ_IN[3]) && $past(s_q.interrupt_mask[3]));
  endproperty
  a_tx_gate: assert property (p_tx_gate)
    else $error("transmit level interrupt gating wrong");

  property p_rx_gate;
    ##1 MASKED_IRQ_STATUS_OUT[2] == ($past(RAW_IRQ_IN[2]) && $past(s_q.interrupt_mask[2]));
  endproperty
  a_rx_gate: assert property (p_rx_gate)
    else $error("receive level interrupt gating wrong");

  property p_rt_gate;
    ##1 MASKED_IRQ_STATUS_OUT[1] == ($past(RAW_IRQ_IN[1]) && $past(s_q.interrupt_mask[1]));
  endproperty
  a_rt_gate: assert property (p_rt_gate)
    else $error("receive timeout interrupt gating wrong");

  property p_ror_gate;
    ##1 MASKED_IRQ_STATUS_OUT[0] == ($past(RAW_IRQ_IN[0]) && $past(s_q.interrupt_mask[0]));
  endproperty
  a_ror_gate: assert property (p_ror_gate)
    else $error("receive overrun interrupt gating wrong");

  // masked status read returns raw and mask and leaves the event flags alone
  property p_masked_read;
    (ar_hs && rd_ofs == spr_pkg::OFS_MASKED)
      |=> S_AXI_RDATA_OUT[3:0] == ($past(RAW_IRQ_IN) & $past(s_q.interrupt_mask))
      && !$past(event_clr);
  endproperty
  a_masked_read: assert property (p_masked_read)
    else $error("masked status read wrong or has a side effect");

  // an enabled source rising raises the interrupt on the next edge
  property p_irq_raise;
    ((RAW_IRQ_IN & ~$past(RAW_IRQ_IN) & s_q.interrupt_mask) != 4'h0) |=> IRQ_OUT;
  endproperty
  a_irq_raise: assert property (p_irq_raise)
    else $error("enabled event did not raise the interrupt");

  // main scenarios
  c_div_write: cover property (do_write && wr_ofs == spr_pkg::OFS_PRESCALE);
  c_mask_read: cover property (ar_hs && rd_ofs == spr_pkg::OFS_MASK ##1 S_AXI_RVALID_OUT);
  c_irq_clear: cover property (IRQ_OUT ##1 event_clr ##2 !IRQ_OUT);
  c_unmapped: cover property (S_AXI_RVALID_OUT && S_AXI_RRESP_OUT == spr_pkg::RESP_DECERR);
endmodule

/* File: ssp_prescale_and_irq_mask_tb.sv */
// self-checking bench for the prescale and interrupt mask register bank
`timescale 1ns/1ps
module ssp_prescale_and_irq_mask_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] raw = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, tick, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] divisor;
  logic [3:0] masked;
  logic [33:0] exp_r;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int bad_count = 0;
  int checked = 0;
  integer seed = 64828;

  // free-running core clock
  always #(spr_pkg::CLK_PERIOD_NS / 2) clk = ~clk;

  spr_regs u_dut (
    .CORE_CLK_IN(clk),
    .RESETN_IN(rst_n),
    .S_AXI_AWVALID_IN(awvalid),
    .S_AXI_AWREADY_OUT(awready),
    .S_AXI_AWADDR_IN(awaddr),
    .S_AXI_AWPROT_IN(3'h0),
    .S_AXI_WVALID_IN(wvalid),
    .S_AXI_WREADY_OUT(wready),
    .S_AXI_WDATA_IN(wdata),
    .S_AXI_WSTRB_IN(4'hF),
    .S_AXI_BVALID_OUT(bvalid),
    .S_AXI_BREADY_IN(1'b1),
    .S_AXI_BRESP_OUT(bresp),
    .S_AXI_ARVALID_IN(arvalid),
    .S_AXI_ARREADY_OUT(arready),
    .S_AXI_ARADDR_IN(araddr),
    .S_AXI_ARPROT_IN(3'h0),
    .S_AXI_RVALID_OUT(rvalid),
    .S_AXI_RREADY_IN(1'b1),
    .S_AXI_RDATA_OUT(rdata),
    .S_AXI_RRESP_OUT(rresp),
    .RAW_IRQ_IN(raw),
    .PRESCALE_DIVISOR_OUT(divisor),
    .PRESCALE_TICK_OUT(tick),
    .MASKED_IRQ_STATUS_OUT(masked),
    .IRQ_OUT(irq)
  );

  // single comparison point, counts every check
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one compare task per kind of result; all of them count through chk
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    chk(what, exp, got);
  endtask

  task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
    chk(what, 32'(exp), 32'(got));
  endtask

  task automatic chk_pin(input string what, input logic [31:0] exp, input logic [31:0] got);
    chk(what, exp, got);
  endtask

  // the only place the run ends
  task automatic end_of_test();
    $display("checks made %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic give_up(input string what);
    bad_count++;
    $display("wrong value %s expected done seen timeout", what);
    end_of_test();
  endtask

  // ready is sampled at the falling edge, so the handshake edge is known without a race
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic ha, hw, hb;
    bq.push_back(er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(negedge clk);
      ha = awvalid & awready;
      hw = wvalid & wready;
      hb = bvalid;
      @(posedge clk);
      if (ha)
        awvalid <= 1'b0;
      if (hw)
        wvalid <= 1'b0;
      if (hb)
        return;
    end
    give_up("write wait");
  endtask

  // read request; the expected word goes to the queue for the monitor
  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    logic ha, hr;
    rq.push_back({er, ed});
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(negedge clk);
      ha = arvalid & arready;
      hr = rvalid;
      @(posedge clk);
      if (ha)
        arvalid <= 1'b0;
      if (hr)
        return;
    end
    give_up("read wait");
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // spacing between the second and third tick, after the new divisor has settled
  task automatic tick_gap(input int d);
    int n;
    int cnt;
    int t0;
    cnt = 0;
    t0 = 0;
    for (n = 0; n < 600; n++)
    begin
      @(negedge clk);
      if (tick === 1'b1)
      begin
        cnt++;
        if (cnt == 3)
        begin
          chk_pin("tick spacing", 32'(d), 32'(n - t0));
          @(posedge clk);
          return;
        end
        t0 = n;
      end
    end
    give_up("tick wait");
  endtask

  // monitor: each response retires the oldest note of its kind
  always @(negedge clk)
  begin
    if (rst_n && bvalid && bq.size() > 0)
      chk_resp("write response", bq.pop_front(), bresp);
    if (rst_n && rvalid && rq.size() > 0)
    begin
      exp_r = rq.pop_front();
      chk_word("read data", exp_r[31:0], rdata);
      chk_resp("read response", exp_r[33:32], rresp);
    end
  end

  initial
  begin
    int i;
    logic [31:0] v;
    logic [3:0] m;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // write address, write data and read address channels must all be open right after reset
    @(negedge clk);
    chk_pin("ready outputs", 32'h0000_0007, 32'({awready, wready, arready}));
    @(posedge clk);
    axr(spr_pkg::OFS_PRESCALE, 32'(spr_pkg::DIV_RESET), spr_pkg::RESP_OKAY);
    axr(spr_pkg::OFS_MASK, 32'(spr_pkg::MASK_RESET), spr_pkg::RESP_OKAY);
    $display("test reset values done");
    // odd value first, then random divisors in 2..254, back to back
    for (i = 0; i < 6; i++)
    begin
      v = (i == 0) ? 32'h0000_0007 : 32'({$random(seed)} % 253 + 2);
      axw(spr_pkg::OFS_PRESCALE, v, spr_pkg::RESP_OKAY);
      axr(spr_pkg::OFS_PRESCALE, v & 32'(spr_pkg::DIV_LSB_CLR), spr_pkg::RESP_OKAY);
    end
    // software keeps to even divisors here so the tick spacing equals the written value
    v = 32'(2 * ({$random(seed)} % 8 + 1));
    axw(spr_pkg::OFS_PRESCALE, v, spr_pkg::RESP_OKAY);
    @(negedge clk);
    chk_pin("divisor port", v, 32'(divisor));
    @(posedge clk);
    tick_gap(int'(v));
    $display("test prescale done");
    for (i = 0; i < 8; i++)
    begin
      m = 4'($random(seed));
      axw(spr_pkg::OFS_MASK, 32'(m), spr_pkg::RESP_OKAY);
      axr(spr_pkg::OFS_MASK, 32'(m), spr_pkg::RESP_OKAY);
    end
    $display("test mask readback done");
    // one source enabled at a time, then none; all four raw conditions rise together
    for (i = 0; i < 5; i++)
    begin
      m = (i < 4) ? 4'(4'h1 << i) : 4'h0;
      axw(spr_pkg::OFS_MASK, 32'(m), spr_pkg::RESP_OKAY);
      raw <= 4'hF;
      cyc(3);
      @(negedge clk);
      chk_pin("irq level", 32'(m != 4'h0), 32'(irq));
      chk_pin("masked port", 32'(m), 32'(masked));
      @(posedge clk);
      axr(spr_pkg::OFS_MASKED, 32'(m), spr_pkg::RESP_OKAY);
      axr(spr_pkg::OFS_MASKED, 32'(m), spr_pkg::RESP_OKAY);
      axr(spr_pkg::OFS_RAW, 32'h0000_000F, spr_pkg::RESP_OKAY);
      axr(spr_pkg::OFS_EVENT, 32'h0000_000F, spr_pkg::RESP_OKAY);
      @(negedge clk);
      chk_pin("irq after clear", 32'h0, 32'(irq));
      @(posedge clk);
      raw <= 4'h0;
      cyc(2);
    end
    $display("test interrupt gating done");
    // unmapped offset refused, mask left alone
    axw(8'h20, 32'h0000_00FF, spr_pkg::RESP_DECERR);
    axr(8'h20, spr_pkg::DATA_ZERO, spr_pkg::RESP_DECERR);
    // a write to a status register is accepted but must leave the mask alone
    axw(spr_pkg::OFS_MASKED, 32'h0000_000F, spr_pkg::RESP_OKAY);
    axr(spr_pkg::OFS_MASK, 32'h0000_0000, spr_pkg::RESP_OKAY);
    cyc(4);
    $display("test unmapped done");
    end_of_test();
  end
endmodule
